// >>> hw/tag_cfg.svh
// Register indexes, field positions, key and reset values of the trace access gate.
`ifndef TAG_CFG_SVH
`define TAG_CFG_SVH
// ==========================================================================
// Register index map
`define TAG_IDX_W            10
`define TAG_IDX_MAIN_CTRL    10'h000
`define TAG_IDX_OS_LOCK_ACC  10'h0c0
`define TAG_IDX_OS_LOCK_STAT 10'h0c1
`define TAG_IDX_OS_SAVE_REST 10'h0c2
`define TAG_IDX_PD_STAT      10'h0c5
`define TAG_IDX_RSVD_TRACE   10'h100
`define TAG_IDX_MGMT_BASE    10'h3c0
`define TAG_IDX_SW_LOCK_ACC  10'h3ec
`define TAG_IDX_SW_LOCK_STAT 10'h3ed
`define TAG_IDX_AUTH_STAT    10'h3ee
`define TAG_IDX_DEV_ID       10'h3f2
// ==========================================================================
// Fields, key and reset values
`define TAG_LOCK_KEY         32'hc5acce55
`define TAG_PD_BIT           0
`define TAG_LOCK_IMPL_BIT    0
`define TAG_LOCK_SET_BIT     1
`define TAG_PDSR_PWR_BIT     0
`define TAG_UNK_VALUE        32'h0000_0000
`define TAG_SW_LOCK_RST      1'b1
`define TAG_OS_LOCK_RST      1'b0
`define TAG_PD_RST           1'b1
`endif

// >>> hw/tag_pkg.sv
// Types shared by the trace access gate modules.
package tag_pkg;
    // Source of a register access.
    typedef enum logic [1:0] {
        TAG_SRC_DBG_MM  = 2'h0,
        TAG_SRC_DBG_JTG = 2'h1,
        TAG_SRC_PROC_MM = 2'h2,
        TAG_SRC_COPROC  = 2'h3
    } tag_src_e;
    // Register class of an index.
    typedef enum logic [3:0] {
        TAG_CL_TRACE = 4'h0, TAG_CL_LOCK_STAT = 4'h1, TAG_CL_LOCK_ACC = 4'h2,
        TAG_CL_PD_STAT = 4'h3, TAG_CL_OSL_STAT = 4'h4, TAG_CL_OSL_ACC = 4'h5,
        TAG_CL_OS_SR = 4'h6, TAG_CL_ID = 4'h7, TAG_CL_MGMT = 4'h8,
        TAG_CL_RSVD_TRACE = 4'h9, TAG_CL_RSVD_MGMT = 4'ha
    } tag_class_e;
    // Response code returned with each access.
    typedef enum logic [2:0] {
        TAG_RSP_OK = 3'h0, TAG_RSP_ERROR = 3'h1, TAG_RSP_NOT_POSSIBLE_RESPONSE = 3'h2,
        TAG_RSP_WI = 3'h3, TAG_RSP_UNP = 3'h4, TAG_RSP_UNK_SBZP = 3'h5
    } tag_rsp_e;
    // Macrocell state seen by one access, one-hot.
    typedef enum logic [2:0] {
        TAG_ST_NO_POWER  = 3'b001,
        TAG_ST_NON_PRIV  = 3'b010,
        TAG_ST_OTHERWISE = 3'b100
    } tag_pstate_e;
endpackage : tag_pkg

// >>> hw/tag_class_decode.sv
// Maps a register index onto its register class.
`timescale 1ns/10ps
`include "tag_cfg.svh"
module tag_class_decode (
    // Index in
    input  wire logic [`TAG_IDX_W-1:0] idx,
    // Class out
    output tag_pkg::tag_class_e        reg_class
);
    import tag_pkg::*;

    // ==========================================================================
    // Decode
    // Named management registers win over the range decode below them.
    always_comb begin
        case (idx)
            `TAG_IDX_OS_LOCK_ACC:  reg_class = TAG_CL_OSL_ACC;
            `TAG_IDX_OS_LOCK_STAT: reg_class = TAG_CL_OSL_STAT;
            `TAG_IDX_OS_SAVE_REST: reg_class = TAG_CL_OS_SR;
            `TAG_IDX_PD_STAT:      reg_class = TAG_CL_PD_STAT;
            `TAG_IDX_SW_LOCK_ACC:  reg_class = TAG_CL_LOCK_ACC;
            `TAG_IDX_SW_LOCK_STAT: reg_class = TAG_CL_LOCK_STAT;
            `TAG_IDX_AUTH_STAT:    reg_class = TAG_CL_ID;
            `TAG_IDX_DEV_ID:       reg_class = TAG_CL_ID;
            default: begin
                if (idx < `TAG_IDX_OS_LOCK_ACC) begin
                    reg_class = TAG_CL_TRACE;
                end else if (idx < `TAG_IDX_RSVD_TRACE) begin
                    reg_class = TAG_CL_RSVD_MGMT;
                end else if (idx < `TAG_IDX_MGMT_BASE) begin
                    reg_class = TAG_CL_RSVD_TRACE;
                end else begin
                    reg_class = TAG_CL_MGMT;
                end
            end
        endcase
    end
endmodule : tag_class_decode

// >>> hw/tag_gate.sv
// Access-permission gate in front of the trace macrocell register file.
`timescale 1ns/10ps
`include "tag_cfg.svh"
// Contract
// - Error response drops write data and returns an unknown read value.
// - Memory-mapped error is a bus error; coprocessor error is undefined instruction.
// - Permitted access completes; read-only writes dropped, write-only reads zero.
// - Write-ignored drops the write and reads the current register value.
// - Memory-mapped processor port comes with a software lock via lock access.
// - Debugger and processor memory-mapped accesses are told apart.
// - JTAG blocks management, lock access, save/restore; trace blocked when core down.
// - Software debug enable low makes every processor memory-mapped access an error.
// - Software debug enable never affects debugger or coprocessor accesses.
// - Unpowered when powered down, or for processor memory-mapped when enable is low.
// - Non-privileged state needs power, user mode and trace access disabled.
// - With no defined state, the default permissions of each class apply.
// - Debugger table: error unpowered, otherwise per-class single-power responses.
// - Memory-mapped accesses return error while unpowered.
// - Coprocessor: not-possible unpowered, error non-privileged, else per-class.
// - Not-possible means the access cannot complete; system decides what follows.
// - Power-down bit set drops trace writes except the main control register.
// - Power-down control is bit 0 of the main control register.
// - Software lock set makes processor memory-mapped writes ignored, except writes to lock access.
// - Lock access is invisible to debugger and coprocessor; their writes drop.
// - Key to OS lock access sets OS lock; debugger trace accesses then error.
module tag_gate #(
    parameter int DW = 32
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Access request, one per cycle
    input  wire logic                  req_valid,
    input  tag_pkg::tag_src_e          req_src,
    input  wire logic                  req_write,
    input  wire logic [`TAG_IDX_W-1:0] req_idx,
    input  wire logic [DW-1:0]         req_wdata,
    // Response, one cycle after the request
    output logic                       rsp_valid,
    output tag_pkg::tag_rsp_e          rsp_code,
    output logic [DW-1:0]              rsp_rdata,
    output logic                       rsp_bus_error,
    output logic                       rsp_undef_instr,
    // Register file side
    output logic [`TAG_IDX_W-1:0]      rf_rd_idx,
    input  wire logic [DW-1:0]         rf_rd_data,
    output logic                       rf_wr_en,
    output logic [`TAG_IDX_W-1:0]      rf_wr_idx,
    output logic [DW-1:0]              rf_wr_data,
    // System status, asynchronous pins
    input  wire logic                  macrocell_powered,
    input  wire logic                  core_powered,
    input  wire logic                  software_debug_enable,
    // Processor status, same clock
    input  wire logic                  proc_privileged,
    input  wire logic                  coproc_trace_disabled,
    // Lock and power-down state
    output logic                       sw_lock_set,
    output logic                       os_lock_set,
    output logic                       powerdown_control_bit
);
    import tag_pkg::*;

    typedef struct packed {
        logic [2:0]            sync1;
        logic [2:0]            sync2;
        logic                  sw_lock;
        logic                  os_lock;
        logic                  pd;
        logic                  rsp_valid;
        tag_rsp_e              rsp_code;
        tag_src_e              rsp_src;
        logic [DW-1:0]         rsp_rdata;
        logic                  wr_en;
        logic [`TAG_IDX_W-1:0] wr_idx;
        logic [DW-1:0]         wr_data;
    } tag_state_s;

    tag_state_s  st_r;
    tag_state_s  st_nxt;
    tag_class_e  req_class;
    tag_pstate_e pstate;
    tag_rsp_e    code;
    logic        pwr_s;
    logic        core_s;
    logic        swen_s;
    logic        is_dbg;
    logic        is_mgmt;
    logic [DW-1:0] own_rd;
    logic        own_reg;

    tag_class_decode u_decode (
        .idx       (req_idx),
        .reg_class (req_class)
    );

    // ==========================================================================
    // Status inputs after the second synchroniser stage
    assign pwr_s  = st_r.sync2[0];
    assign core_s = st_r.sync2[1];
    assign swen_s = st_r.sync2[2];
    // The memory-mapped debugger and processor paths arrive tagged separately.
    assign is_dbg  = (req_src == TAG_SRC_DBG_MM) || (req_src == TAG_SRC_DBG_JTG);
    assign is_mgmt = (req_class != TAG_CL_TRACE) && (req_class != TAG_CL_RSVD_TRACE);
    assign rf_rd_idx = req_idx;

    // ==========================================================================
    // Macrocell state of the present access
    // The enable only gates the processor memory-mapped path, never the others.
    always_comb begin
        if (!pwr_s || (req_src == TAG_SRC_PROC_MM && !swen_s)) begin
            pstate = TAG_ST_NO_POWER;
        end else if (req_src == TAG_SRC_COPROC && !proc_privileged
                     && coproc_trace_disabled) begin
            pstate = TAG_ST_NON_PRIV;
        end else begin
            pstate = TAG_ST_OTHERWISE;
        end
    end

    // ==========================================================================
    // Response code from state, source and class
    always_comb begin
        code = TAG_RSP_OK;
        case (pstate)
            TAG_ST_NO_POWER: begin
                // A powered-down macrocell cannot complete the coprocessor access.
                code = (req_src == TAG_SRC_COPROC) ? TAG_RSP_NOT_POSSIBLE_RESPONSE : TAG_RSP_ERROR;
            end
            TAG_ST_NON_PRIV: begin
                code = TAG_RSP_ERROR;
            end
            TAG_ST_OTHERWISE: begin
                if (req_src == TAG_SRC_DBG_JTG && (is_mgmt
                        || (req_class == TAG_CL_TRACE && !core_s))) begin
                    code = TAG_RSP_ERROR;
                end else if (is_dbg && st_r.os_lock && req_class == TAG_CL_TRACE) begin
                    code = TAG_RSP_ERROR;
                end else begin
                    case (req_class)
                        TAG_CL_TRACE: begin
                            if (req_write && st_r.pd && req_idx != `TAG_IDX_MAIN_CTRL) begin
                                code = TAG_RSP_WI;
                            end else if (req_src == TAG_SRC_PROC_MM && st_r.sw_lock) begin
                                code = TAG_RSP_WI;
                            end
                        end
                        TAG_CL_LOCK_ACC: begin
                            if (req_src != TAG_SRC_PROC_MM) begin
                                code = TAG_RSP_WI;
                            end
                        end
                        TAG_CL_OSL_ACC, TAG_CL_MGMT: begin
                            if (req_src == TAG_SRC_PROC_MM && st_r.sw_lock) begin
                                code = TAG_RSP_WI;
                            end
                        end
                        TAG_CL_OS_SR: code = TAG_RSP_UNP;
                        TAG_CL_RSVD_TRACE, TAG_CL_RSVD_MGMT: code = TAG_RSP_UNK_SBZP;
                        default: code = TAG_RSP_OK;
                    endcase
                end
            end
            default: code = TAG_RSP_ERROR;
        endcase
    end

    // ==========================================================================
    // Read values of the registers the gate holds itself
    // Lock status reads zero off the processor port, where the lock never applies.
    always_comb begin
        own_rd  = '0;
        own_reg = 1'b1;
        case (req_class)
            TAG_CL_LOCK_STAT: begin
                if (req_src == TAG_SRC_PROC_MM) begin
                    own_rd[`TAG_LOCK_IMPL_BIT] = 1'b1;
                    own_rd[`TAG_LOCK_SET_BIT]  = st_r.sw_lock;
                end
            end
            TAG_CL_OSL_STAT: begin
                own_rd[`TAG_LOCK_IMPL_BIT] = 1'b1;
                own_rd[`TAG_LOCK_SET_BIT]  = st_r.os_lock;
            end
            TAG_CL_PD_STAT: own_rd[`TAG_PDSR_PWR_BIT] = core_s;
            TAG_CL_LOCK_ACC, TAG_CL_OSL_ACC: own_rd = '0;
            default: own_reg = 1'b0;
        endcase
    end

    // ==========================================================================
    // Next state: synchronisers, lock state, response and write forwarding
    always_comb begin
        st_nxt           = st_r;
        st_nxt.sync1     = {software_debug_enable, core_powered, macrocell_powered};
        st_nxt.sync2     = st_r.sync1;
        st_nxt.rsp_valid = req_valid;
        st_nxt.wr_en     = 1'b0;
        st_nxt.wr_idx    = req_idx;
        st_nxt.wr_data   = req_wdata;
        if (req_valid) begin
            st_nxt.rsp_code = code;
            st_nxt.rsp_src  = req_src;
            case (code)
                TAG_RSP_OK: begin
                    st_nxt.rsp_rdata = own_reg ? own_rd : rf_rd_data;
                    if (req_write) begin
                        case (req_class)
                            TAG_CL_LOCK_ACC: begin
                                st_nxt.sw_lock = (req_wdata != `TAG_LOCK_KEY);
                            end
                            TAG_CL_OSL_ACC: begin
                                st_nxt.os_lock = (req_wdata == `TAG_LOCK_KEY);
                            end
                            // Read-only and status classes drop the write.
                            TAG_CL_TRACE, TAG_CL_MGMT: begin
                                st_nxt.wr_en = 1'b1;
                                if (req_idx == `TAG_IDX_MAIN_CTRL) begin
                                    st_nxt.pd = req_wdata[`TAG_PD_BIT];
                                end
                            end
                            default: st_nxt.wr_en = 1'b0;
                        endcase
                    end
                end
                TAG_RSP_WI: begin
                    st_nxt.rsp_rdata = own_reg ? own_rd : rf_rd_data;
                end
                TAG_RSP_UNK_SBZP: begin
                    st_nxt.rsp_rdata = '0;
                end
                default: begin
                    // Error, not-possible and unpredictable never touch state.
                    st_nxt.rsp_rdata = DW'(`TAG_UNK_VALUE);
                end
            endcase
        end
    end

    // ==========================================================================
    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r           <= '0;
            st_r.sw_lock   <= `TAG_SW_LOCK_RST;
            st_r.os_lock   <= `TAG_OS_LOCK_RST;
            st_r.pd        <= `TAG_PD_RST;
            st_r.rsp_code  <= TAG_RSP_OK;
            st_r.rsp_src   <= TAG_SRC_DBG_MM;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================================
    // Outputs
    assign rsp_valid       = st_r.rsp_valid;
    assign rsp_code        = st_r.rsp_code;
    assign rsp_rdata       = st_r.rsp_rdata;
    assign rsp_bus_error   = st_r.rsp_valid && st_r.rsp_code == TAG_RSP_ERROR
                             && st_r.rsp_src != TAG_SRC_COPROC;
    assign rsp_undef_instr = st_r.rsp_valid && st_r.rsp_code == TAG_RSP_ERROR
                             && st_r.rsp_src == TAG_SRC_COPROC;
    assign rf_wr_en        = st_r.wr_en;
    assign rf_wr_idx       = st_r.wr_idx;
    assign rf_wr_data      = st_r.wr_data;
    assign sw_lock_set     = st_r.sw_lock;
    assign os_lock_set     = st_r.os_lock;
    assign powerdown_control_bit = st_r.pd;

    // ==========================================================================
    // Assertions
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence sw_unlock_s;
        req_valid && req_src == TAG_SRC_PROC_MM && req_write && pwr_s && swen_s
        && req_idx == `TAG_IDX_SW_LOCK_ACC && req_wdata == `TAG_LOCK_KEY;
    endsequence
    sequence dbg_trace_s;
        req_valid && is_dbg && req_class == TAG_CL_TRACE && pwr_s;
    endsequence

    err_drop_a: assert property (
        rsp_valid && rsp_code == TAG_RSP_ERROR |-> !rf_wr_en && rsp_rdata == DW'(`TAG_UNK_VALUE))
        else $error("error response wrote data or returned a known value");
    err_signal_a: assert property (
        rsp_valid && rsp_code == TAG_RSP_ERROR |-> rsp_bus_error != rsp_undef_instr)
        else $error("error response not signalled on exactly one path");
    swen_block_a: assert property (
        req_valid && req_src == TAG_SRC_PROC_MM && !swen_s |=> rsp_bus_error)
        else $error("processor access passed with debug enable low");
    copro_npos_a: assert property (
        req_valid && req_src == TAG_SRC_COPROC && !pwr_s |=> rsp_code == TAG_RSP_NOT_POSSIBLE_RESPONSE)
        else $error("unpowered coprocessor access not flagged not-possible");
    jtag_mgmt_a: assert property (
        req_valid && req_src == TAG_SRC_DBG_JTG && is_mgmt |=> rsp_code == TAG_RSP_ERROR)
        else $error("jtag reached a management register");
    pd_drop_a: assert property (
        req_valid && req_write && st_r.pd && req_class == TAG_CL_TRACE
        && req_idx != `TAG_IDX_MAIN_CTRL |=> !rf_wr_en)
        else $error("trace write forwarded while powered down");
    unlock_seq_a: assert property (
        sw_unlock_s |=> !sw_lock_set ##1 !sw_lock_set || $past(req_valid))
        else $error("lock key did not open the software lock");
    os_lock_err_a: assert property (
        dbg_trace_s and os_lock_set |=> rsp_code == TAG_RSP_ERROR)
        else $error("debugger trace access passed under os lock");
    nonpriv_err_a: assert property (
        req_valid && req_src == TAG_SRC_COPROC && pwr_s && !proc_privileged
        && coproc_trace_disabled |=> rsp_undef_instr)
        else $error("non-privileged coprocessor access not refused");
    lock_wi_a: assert property (
        req_valid && req_src == TAG_SRC_PROC_MM && sw_lock_set && req_write
        && req_class == TAG_CL_TRACE |=> !rf_wr_en)
        else $error("write passed the software lock");
endmodule : tag_gate

// >>> bench/tag_rf_model.sv
// Behavioural register file that answers the gate's register side.
`timescale 1ns/10ps
module tag_rf_model (
    // Clock
    input  wire logic        clk,
    // Read port, answered in the same cycle
    input  wire logic [9:0]  rd_idx,
    output logic      [31:0] rd_data,
    // Write port
    input  wire logic        wr_en,
    input  wire logic [9:0]  wr_idx,
    input  wire logic [31:0] wr_data
);
    logic [31:0] mem_r [1024];

    // Each word starts as a pattern holding its own index, so a wrong index shows up.
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem_r[i] = 32'h5a00_0000 | 32'(i);
        end
    end

    // Reads are combinational because the gate samples them in the request cycle.
    assign rd_data = mem_r[rd_idx];

    // Writes land on the edge that carries the gate's write strobe.
    always @(posedge clk) begin
        if (wr_en) begin
            mem_r[wr_idx] <= wr_data;
        end
    end
endmodule : tag_rf_model

// >>> bench/tb_top.sv
// Self-checking bench: corner and random accesses through the gate.
`timescale 1ns/10ps
`include "tag_cfg.svh"
module tb_top;
    import tag_pkg::*;
    // ==========================================================================
    // Signals and mirror state
    logic        clk, rst, req_valid, req_write, rsp_valid, rsp_bus_error, rsp_undef_instr;
    logic        rf_wr_en, mc, core, swen, priv, trdis, sw_lock_set, os_lock_set, pd_bit;
    logic        s_lock, o_lock, pd;
    tag_src_e    req_src;
    tag_rsp_e    rsp_code;
    logic [9:0]  req_idx, rf_rd_idx, rf_wr_idx;
    logic [31:0] req_wdata, rsp_rdata, rf_rd_data, rf_wr_data;
    logic [31:0] shadow [1024];
    logic [9:0]  tab [14] = '{10'h000, 10'h001, 10'h0c0, 10'h0c1, 10'h0c2, 10'h0c5, 10'h0d0,
                              10'h100, 10'h3c0, 10'h3ec, 10'h3ed, 10'h3ee, 10'h3f2, 10'h3c7};
    int          fail_count, comparisons, seed;

    tag_gate #(.DW(32)) tag_gate_inst (.clk(clk), .rst(rst), .req_valid(req_valid),
        .req_src(req_src), .req_write(req_write), .req_idx(req_idx), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_code(rsp_code), .rsp_rdata(rsp_rdata),
        .rsp_bus_error(rsp_bus_error), .rsp_undef_instr(rsp_undef_instr),
        .rf_rd_idx(rf_rd_idx), .rf_rd_data(rf_rd_data), .rf_wr_en(rf_wr_en),
        .rf_wr_idx(rf_wr_idx), .rf_wr_data(rf_wr_data), .macrocell_powered(mc),
        .core_powered(core), .software_debug_enable(swen), .proc_privileged(priv),
        .coproc_trace_disabled(trdis), .sw_lock_set(sw_lock_set),
        .os_lock_set(os_lock_set), .powerdown_control_bit(pd_bit));

    tag_rf_model tag_rf_model_inst (.clk(clk), .rd_idx(rf_rd_idx), .rd_data(rf_rd_data),
        .wr_en(rf_wr_en), .wr_idx(rf_wr_idx), .wr_data(rf_wr_data));

    // Free-running bench clock, 4 ns period.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Compare and count; case inequality so an unknown never passes.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Register class of an index, as the bench expects it.
    function automatic tag_class_e cls(input logic [9:0] i);
        case (i)
            `TAG_IDX_OS_LOCK_ACC:  return TAG_CL_OSL_ACC;
            `TAG_IDX_OS_LOCK_STAT: return TAG_CL_OSL_STAT;
            `TAG_IDX_OS_SAVE_REST: return TAG_CL_OS_SR;
            `TAG_IDX_PD_STAT:      return TAG_CL_PD_STAT;
            `TAG_IDX_SW_LOCK_ACC:  return TAG_CL_LOCK_ACC;
            `TAG_IDX_SW_LOCK_STAT: return TAG_CL_LOCK_STAT;
            `TAG_IDX_AUTH_STAT:    return TAG_CL_ID;
            `TAG_IDX_DEV_ID:       return TAG_CL_ID;
            default: ;
        endcase
        if (i < 10'h0c0) return TAG_CL_TRACE;
        if (i < 10'h100) return TAG_CL_RSVD_MGMT;
        if (i < 10'h3c0) return TAG_CL_RSVD_TRACE;
        return TAG_CL_MGMT;
    endfunction : cls

    // Expected response from the mirrored power, privilege and lock state.
    function automatic tag_rsp_e ecode(input tag_src_e s, input logic w, input logic [9:0] i);
        tag_class_e c = cls(i);
        if (!mc || (s == TAG_SRC_PROC_MM && !swen)) begin
            return (s == TAG_SRC_COPROC) ? TAG_RSP_NOT_POSSIBLE_RESPONSE : TAG_RSP_ERROR;
        end
        if (s == TAG_SRC_COPROC && !priv && trdis) return TAG_RSP_ERROR;
        // Reserved trace locations stay reachable over the direct link, like trace ones.
        if (s == TAG_SRC_DBG_JTG && ((c != TAG_CL_TRACE && c != TAG_CL_RSVD_TRACE)
            || (c == TAG_CL_TRACE && !core))) return TAG_RSP_ERROR;
        if (s inside {TAG_SRC_DBG_MM, TAG_SRC_DBG_JTG} && c == TAG_CL_TRACE && o_lock) begin
            return TAG_RSP_ERROR;
        end
        if (c == TAG_CL_TRACE && w && pd && i != 10'h000) return TAG_RSP_WI;
        if (s == TAG_SRC_PROC_MM && s_lock &&
            c inside {TAG_CL_TRACE, TAG_CL_MGMT, TAG_CL_OSL_ACC}) return TAG_RSP_WI;
        if (c == TAG_CL_LOCK_ACC && s != TAG_SRC_PROC_MM) return TAG_RSP_WI;
        if (c == TAG_CL_OS_SR) return TAG_RSP_UNP;
        if (c inside {TAG_CL_RSVD_TRACE, TAG_CL_RSVD_MGMT}) return TAG_RSP_UNK_SBZP;
        return TAG_RSP_OK;
    endfunction : ecode

    // One access: request for one cycle, then check the one-cycle response.
    task automatic acc(input tag_src_e s, input logic w, input logic [9:0] i, input logic [31:0] d);
        tag_rsp_e   ec;
        tag_class_e c;
        logic [31:0] er;
        ec = ecode(s, w, i);
        c = cls(i);
        er = 32'h0;
        if (ec inside {TAG_RSP_OK, TAG_RSP_WI} &&
            c inside {TAG_CL_TRACE, TAG_CL_MGMT, TAG_CL_ID}) er = shadow[i];
        if (ec == TAG_RSP_OK && c == TAG_CL_LOCK_STAT && s == TAG_SRC_PROC_MM) begin
            er = {30'h0, s_lock, 1'b1};
        end
        if (ec == TAG_RSP_OK && c == TAG_CL_OSL_STAT) er = {30'h0, o_lock, 1'b1};
        if (ec == TAG_RSP_OK && c == TAG_CL_PD_STAT) er = {31'h0, core};
        @(posedge clk);
        #1;
        {req_valid, req_src, req_write, req_idx, req_wdata} = {1'b1, s, w, i, d};
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        check(rsp_valid, 1);
        check(rsp_code, ec);
        check(rsp_bus_error, ec == TAG_RSP_ERROR && s != TAG_SRC_COPROC);
        check(rsp_undef_instr, ec == TAG_RSP_ERROR && s == TAG_SRC_COPROC);
        check(rf_wr_en, w && ec == TAG_RSP_OK && c inside {TAG_CL_TRACE, TAG_CL_MGMT});
        if (w && ec == TAG_RSP_OK && c inside {TAG_CL_TRACE, TAG_CL_MGMT}) begin
            check({22'h0, rf_wr_idx}, {22'h0, i});
            check(rf_wr_data, d);
        end
        if (!w) check(rsp_rdata, er);
        if (w && ec == TAG_RSP_OK) begin
            if (c inside {TAG_CL_TRACE, TAG_CL_MGMT}) shadow[i] = d;
            if (c == TAG_CL_LOCK_ACC) s_lock = (d !== `TAG_LOCK_KEY);
            if (c == TAG_CL_OSL_ACC) o_lock = (d === `TAG_LOCK_KEY);
            if (i == `TAG_IDX_MAIN_CTRL) pd = d[`TAG_PD_BIT];
        end
        check({sw_lock_set, os_lock_set, pd_bit}, {s_lock, o_lock, pd});
    endtask : acc

    // Change the synchronised status pins and let the two-flop stages fill.
    task automatic set_status(input logic m, input logic k, input logic e);
        @(posedge clk);
        #1;
        {mc, core, swen} = {m, k, e};
        repeat (3) @(posedge clk);
        #1;
    endtask : set_status

    // Print counts and verdict, then stop.
    task automatic give_verdict();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Cut a hang short well after the expected run length.
    initial begin
        #60000;
        fail_count++;
        give_verdict();
    end

    // Main sequence: reset, hand-made corners, then sweeps over sources and indexes.
    initial begin
        {rst, req_valid, req_write, req_idx, req_wdata, req_src} = '0;
        {mc, core, swen, priv, trdis} = 5'b11110;
        {s_lock, o_lock, pd} = 3'b101;
        fail_count = 0;
        comparisons = 0;
        seed = $urandom(32'hf271);
        for (int i = 0; i < 1024; i++) shadow[i] = 32'h5a00_0000 | 32'(i);
        rst = 1'b1;
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge clk);
        check({sw_lock_set, os_lock_set, pd_bit}, 3'b101);
        acc(TAG_SRC_PROC_MM, 1, 10'h001, 32'h1234_5678);
        acc(TAG_SRC_PROC_MM, 1, `TAG_IDX_SW_LOCK_ACC, `TAG_LOCK_KEY);
        acc(TAG_SRC_PROC_MM, 1, 10'h001, 32'h0bad_f00d);
        acc(TAG_SRC_PROC_MM, 1, `TAG_IDX_MAIN_CTRL, 32'h0000_0000);
        acc(TAG_SRC_PROC_MM, 1, 10'h001, 32'hcafe_0001);
        acc(TAG_SRC_PROC_MM, 0, 10'h001, 32'h0);
        acc(TAG_SRC_DBG_MM, 1, `TAG_IDX_OS_LOCK_ACC, `TAG_LOCK_KEY);
        for (int s = 0; s < 4; s++) acc(tag_src_e'(s), 0, 10'h001, 32'h0);
        acc(TAG_SRC_DBG_MM, 1, `TAG_IDX_OS_LOCK_ACC, 32'h0);
        for (int p = 0; p < 10; p++) begin
            case (p)
                0: set_status(1, 1, 1);
                1: {priv, trdis} = 2'b01;
                2: set_status(1, 1, 0);
                3: set_status(0, 1, 1);
                4: set_status(1, 0, 1);
                default: set_status($urandom % 4 != 0, $urandom % 3 != 0, $urandom % 3 != 0);
            endcase
            if (p > 4) {priv, trdis} = 2'($urandom);
            for (int s = 0; s < 4; s++) begin
                foreach (tab[t]) begin
                    acc(tag_src_e'(s), 1'($urandom), ($urandom % 5 == 0) ? 10'($urandom) : tab[t],
                        ($urandom % 6 == 0) ? `TAG_LOCK_KEY : $urandom);
                end
            end
            if (p == 1) {priv, trdis} = 2'b10;
        end
        give_verdict();
    end
endmodule : tb_top
